// *** shared/ldt_params.svh ***
`ifndef LDT_PARAMS_SVH
`define LDT_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LDT_OFF_CTRL 12'h000
`define LDT_OFF_CMD 12'h004
`define LDT_OFF_STATUS 12'h008
`define LDT_OFF_CNT 12'h00C
`define LDT_OFF_MATCH_A_VALUE 12'h010
`define LDT_OFF_MATCH_B_VALUE 12'h014
`define LDT_OFF_REPEAT_COUNT_A 12'h018
`define LDT_OFF_REPEAT_COUNT_B 12'h01C
`define LDT_OFF_FLAGS 12'h020
`define LDT_OFF_FLAGCLR 12'h024

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LDT_CMD_START 0
`define LDT_CMD_STOP 1
`define LDT_CMD_CLEAR 2
`define LDT_STATUS_RUNNING 0

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define LDT_CTRL_W 7
`define LDT_FLAG_W 5
`define LDT_CNT_ALL_ONES 16'hFFFF
`define LDT_CNT_RESET 16'h0000
`define LDT_COMP_RESET 16'h0000
`define LDT_REP_RESET 8'h00
`define LDT_CTRL_RESET 7'h00
`define LDT_FLAG_RESET 5'h00
`define LDT_HALT_DELAY 2

`endif

// *** shared/ldt_pkg.sv ***
package ldt_pkg;

    typedef enum logic [1:0] {
        RP_FREE,
        RP_ONESHOT,
        RP_BUFFERED,
        RP_DOUBLE
    } ldt_repeat_t;

    typedef struct packed {
        logic run_while_cpu_halted;
        logic rtc_ch1_trigger_enable;
        logic rtc_ch0_trigger_enable;
        ldt_repeat_t repeat_policy_select;
        logic buffered_top_enable;
        logic top_from_match_a;
    } ldt_ctrl_t;

    typedef struct packed {
        logic rep_b_done;
        logic rep_a_done;
        logic match_b;
        logic match_a;
        logic underflow_flag;
    } ldt_flags_t;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } ldt_state_t;

endpackage : ldt_pkg

// *** rtl/ldt_timer.sv ***
// Behaviour
// - Start runs the counter, stop halts it; stop wins when both arrive.
// - Running status bit is high exactly while the counter is running.
// - 16-bit down counter is readable, writes ignored; only clear modifies it.
// - Clear with start zeroes the counter, then runs from the top value.
// - Match flags set when counter equals match_a_value or match_b_value.
// - Underflow reloads match_a_value if top_from_match_a, else all ones.
// - Underflow flag is raised on the tick the counter steps from zero and reloads.
// - Buffered top copies match_b_value into match_a_value as count A nears zero.
// - Software write to match_a_value beats a buffered top reload.
// - Repeat policy: 00 free, 01 one-shot, 10 buffered, 11 double.
// - One-shot decrements count A per underflow, stops on one-to-zero.
// - Software write to count A beats a same-cycle decrement.
// - Buffered mode reloads A from nonzero unused B, else stops.
// - Buffered start with counter and A zero, B nonzero loads B into A.
// - Double mode runs while either count nonzero, decrementing each nonzero count.
// - Double mode write while running gives at least that many underflows.
// - A-done on A reaching zero or buffered reload; B-done on B reaching zero.
// - Clear forces zero; following wrap has no underflow; counts, compares untouched.
// - Real time counter channel 0/1 matches start the timer when enabled.
// - Trigger while running keeps it running.
// - Without run_while_cpu_halted, freeze two ticks after halt, resume two after.
// - Both repeat counters are 8-bit registers.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ldt_params.svh"
`default_nettype none

module ldt_timer (
    input wire logic I_CLK,           // System clock, 125 MHz
    input wire logic I_RST,           // Synchronous reset, active high
    input wire logic I_PSEL,          // APB select
    input wire logic I_PENABLE,       // APB enable
    input wire logic I_PWRITE,        // APB direction
    input wire logic [11:0] I_PADDR,  // APB byte address
    input wire logic [31:0] I_PWDATA, // APB write data
    output logic [31:0] O_PRDATA,     // APB read data
    output logic O_PREADY,            // APB ready
    output logic O_PSLVERR,           // APB error on unmapped address
    input wire logic I_TICK,          // Low frequency clock enable pulse
    input wire logic I_RTC_MATCH0,    // RTC channel 0 match pulse
    input wire logic I_RTC_MATCH1,    // RTC channel 1 match pulse
    input wire logic I_CPU_HALTED,    // CPU halted in debug, level
    output logic O_RUNNING            // Timer running, level
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] dec8(input logic [7:0] v);
        dec8 = (v == 8'h00) ? 8'h00 : v - 8'h01;
    endfunction : dec8

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    // ----------------------------------------
    // State
    // ----------------------------------------
    ldt_pkg::ldt_ctrl_t ctrl_r;
    ldt_pkg::ldt_flags_t flags_r, flags_nxt, ev;
    ldt_pkg::ldt_state_t state_r, state_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] match_a_value_r, match_a_value_nxt;
    logic [15:0] match_b_value_r, match_b_value_nxt;
    logic [7:0] rep_a_r, rep_a_nxt;
    logic [7:0] rep_b_r, rep_b_nxt;
    logic reload_consumed_r, reload_consumed_nxt;
    logic clear_pend_r, clear_pend_nxt;
    logic [`LDT_HALT_DELAY-1:0] halt_pipe_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic running;
    logic uf_stop;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire logic setup = I_PSEL & ~I_PENABLE;
    wire logic wr = I_PSEL & I_PENABLE & I_PWRITE;
    wire logic wr_ctrl = wr & hit(I_PADDR, `LDT_OFF_CTRL);
    wire logic wr_cmd = wr & hit(I_PADDR, `LDT_OFF_CMD);
    wire logic wr_match_a_value = wr & hit(I_PADDR, `LDT_OFF_MATCH_A_VALUE);
    wire logic wr_match_b_value = wr & hit(I_PADDR, `LDT_OFF_MATCH_B_VALUE);
    wire logic wr_rep_a = wr & hit(I_PADDR, `LDT_OFF_REPEAT_COUNT_A);
    wire logic wr_rep_b = wr & hit(I_PADDR, `LDT_OFF_REPEAT_COUNT_B);
    wire logic wr_fclr = wr & hit(I_PADDR, `LDT_OFF_FLAGCLR);
    wire logic mapped = (I_PADDR[1:0] == 2'h0) & (I_PADDR <= `LDT_OFF_FLAGCLR);

    // Strobes only act on a written one
    wire logic cmd_start = wr_cmd & I_PWDATA[`LDT_CMD_START];
    wire logic cmd_stop = wr_cmd & I_PWDATA[`LDT_CMD_STOP];
    wire logic cmd_clear = wr_cmd & I_PWDATA[`LDT_CMD_CLEAR];

    wire logic trig = (I_RTC_MATCH0 & ctrl_r.rtc_ch0_trigger_enable)
        | (I_RTC_MATCH1 & ctrl_r.rtc_ch1_trigger_enable);
    wire logic start_any = cmd_start | trig;

    // ----------------------------------------
    // Debug freeze
    // ----------------------------------------
    // Halt is delayed by two timer ticks to mirror the synchronisation lag
    wire logic freeze = halt_pipe_r[`LDT_HALT_DELAY-1]
        & ~ctrl_r.run_while_cpu_halted;
    wire logic step = running & I_TICK & ~freeze;
    wire logic at_zero = (cnt_r == 16'h0000);
    wire logic uf = step & at_zero & ~clear_pend_r;
    wire logic [15:0] top = ctrl_r.top_from_match_a ? match_a_value_r
        : `LDT_CNT_ALL_ONES;
    wire logic rep_a_last = (rep_a_r == 8'h01);
    wire logic buf_start = (ctrl_r.repeat_policy_select == ldt_pkg::RP_BUFFERED)
        & at_zero & (rep_a_r == 8'h00) & (rep_b_r != 8'h00);

    assign running = (state_r == ldt_pkg::ST_RUN);
    assign O_RUNNING = running;

    // ----------------------------------------
    // Counter and repeat logic
    // ----------------------------------------
    always_comb
    begin
        cnt_nxt = cnt_r;
        match_a_value_nxt = match_a_value_r;
        match_b_value_nxt = match_b_value_r;
        rep_a_nxt = rep_a_r;
        rep_b_nxt = rep_b_r;
        reload_consumed_nxt = reload_consumed_r;
        clear_pend_nxt = clear_pend_r;
        ev = '0;
        uf_stop = 1'b0;
        if (step)
        begin
            if (at_zero)
            begin
                cnt_nxt = top;
                clear_pend_nxt = 1'b0;
            end
            else
                cnt_nxt = cnt_r - 16'h0001;
            ev.match_a = (cnt_r == match_a_value_r);
            ev.match_b = (cnt_r == match_b_value_r);
        end
        if (uf)
        begin
            ev.underflow_flag = 1'b1;
            case (ctrl_r.repeat_policy_select)
                ldt_pkg::RP_FREE: uf_stop = 1'b0; // Runs until stopped
                ldt_pkg::RP_ONESHOT:
                begin
                    rep_a_nxt = dec8(rep_a_r);
                    uf_stop = (rep_a_r <= 8'h01);
                    ev.rep_a_done = rep_a_last;
                    if (rep_a_last & ctrl_r.buffered_top_enable)
                        match_a_value_nxt = match_b_value_r;
                end
                ldt_pkg::RP_BUFFERED:
                begin
                    rep_a_nxt = dec8(rep_a_r);
                    uf_stop = (rep_a_r == 8'h00);
                    if (rep_a_last)
                    begin
                        ev.rep_a_done = 1'b1;
                        if (ctrl_r.buffered_top_enable)
                            match_a_value_nxt = match_b_value_r;
                        if ((rep_b_r != 8'h00) & ~reload_consumed_r)
                        begin
                            rep_a_nxt = rep_b_r;
                            reload_consumed_nxt = 1'b1;
                        end
                        else
                            uf_stop = 1'b1;
                    end
                end
                default:
                begin
                    rep_a_nxt = dec8(rep_a_r);
                    rep_b_nxt = dec8(rep_b_r);
                    ev.rep_a_done = rep_a_last;
                    ev.rep_b_done = (rep_b_r == 8'h01);
                    uf_stop = (rep_a_r <= 8'h01) & (rep_b_r <= 8'h01);
                    if (rep_a_last & ctrl_r.buffered_top_enable)
                        match_a_value_nxt = match_b_value_r;
                end
            endcase
        end
        if (start_any & buf_start & ~running)
        begin
            rep_a_nxt = rep_b_r;
            reload_consumed_nxt = 1'b1;
        end
        // Software writes override the hardware updates above
        if (wr_match_a_value)
            match_a_value_nxt = I_PWDATA[15:0];
        if (wr_match_b_value)
            match_b_value_nxt = I_PWDATA[15:0];
        if (wr_rep_a)
        begin
            rep_a_nxt = I_PWDATA[7:0];
            if (I_PWDATA[7:0] != 8'h00)
                uf_stop = 1'b0;
        end
        if (wr_rep_b)
        begin
            rep_b_nxt = I_PWDATA[7:0];
            reload_consumed_nxt = 1'b0;
            if ((I_PWDATA[7:0] != 8'h00)
                & (ctrl_r.repeat_policy_select == ldt_pkg::RP_DOUBLE))
                uf_stop = 1'b0;
        end
        if (cmd_clear)
        begin
            cnt_nxt = 16'h0000;
            clear_pend_nxt = 1'b1;
        end
    end

    // ----------------------------------------
    // Run state
    // ----------------------------------------
    always_comb
    begin
        case (state_r)
            ldt_pkg::ST_IDLE:
                state_nxt = (start_any & ~cmd_stop) ? ldt_pkg::ST_RUN
                    : ldt_pkg::ST_IDLE;
            ldt_pkg::ST_RUN:
                // Trigger while running only keeps it going
                state_nxt = (cmd_stop | (uf_stop & ~start_any)) ? ldt_pkg::ST_IDLE
                    : ldt_pkg::ST_RUN;
            default:
                state_nxt = ldt_pkg::ST_IDLE;
        endcase
    end

    // Set beats clear for every flag
    assign flags_nxt = ev | (flags_r & ~(wr_fclr ? I_PWDATA[`LDT_FLAG_W-1:0]
        : `LDT_FLAG_RESET));

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire logic [31:0] rd_mux =
        hit(I_PADDR, `LDT_OFF_CTRL) ? {25'h0000000, ctrl_r} :
        hit(I_PADDR, `LDT_OFF_STATUS) ? {31'h00000000, running} :
        hit(I_PADDR, `LDT_OFF_CNT) ? {16'h0000, cnt_r} :
        hit(I_PADDR, `LDT_OFF_MATCH_A_VALUE) ? {16'h0000, match_a_value_r} :
        hit(I_PADDR, `LDT_OFF_MATCH_B_VALUE) ? {16'h0000, match_b_value_r} :
        hit(I_PADDR, `LDT_OFF_REPEAT_COUNT_A) ? {24'h000000, rep_a_r} :
        hit(I_PADDR, `LDT_OFF_REPEAT_COUNT_B) ? {24'h000000, rep_b_r} :
        hit(I_PADDR, `LDT_OFF_FLAGS) ? {27'h0000000, flags_r} :
        32'h00000000; // Command strobes read as zero

    assign O_PRDATA = prdata_r;
    assign O_PREADY = I_PENABLE;
    assign O_PSLVERR = I_PSEL & I_PENABLE & pslverr_r;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            state_r <= ldt_pkg::ST_IDLE;
            ctrl_r <= `LDT_CTRL_RESET;
            flags_r <= `LDT_FLAG_RESET;
            cnt_r <= `LDT_CNT_RESET;
            match_a_value_r <= `LDT_COMP_RESET;
            match_b_value_r <= `LDT_COMP_RESET;
            rep_a_r <= `LDT_REP_RESET;
            rep_b_r <= `LDT_REP_RESET;
            reload_consumed_r <= 1'b0;
            clear_pend_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (wr_ctrl)
                ctrl_r <= I_PWDATA[`LDT_CTRL_W-1:0];
            flags_r <= flags_nxt;
            cnt_r <= cnt_nxt;
            match_a_value_r <= match_a_value_nxt;
            match_b_value_r <= match_b_value_nxt;
            rep_a_r <= rep_a_nxt;
            rep_b_r <= rep_b_nxt;
            reload_consumed_r <= reload_consumed_nxt;
            clear_pend_r <= clear_pend_nxt;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            halt_pipe_r <= '0;
        else if (I_TICK)
            halt_pipe_r <= {halt_pipe_r[`LDT_HALT_DELAY-2:0], I_CPU_HALTED};
    end

    // Read data is captured in the setup cycle so it leaves a flip-flop
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end
        else if (setup)
        begin
            prdata_r <= I_PWRITE ? 32'h00000000 : rd_mux;
            pslverr_r <= ~mapped;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_stop_wins;
        @(posedge I_CLK) disable iff (I_RST)
        (cmd_start & cmd_stop) |=> !O_RUNNING;
    endproperty
    a_stop_wins: assert property (p_stop_wins)
        else $error("start with stop left timer running");
    property p_status;
        @(posedge I_CLK) disable iff (I_RST)
        (setup & !I_PWRITE & hit(I_PADDR, `LDT_OFF_STATUS))
            |=> (O_PRDATA[0] == $past(running)) && (O_PRDATA[31:1] == 31'h00000000);
    endproperty
    a_status: assert property (p_status)
        else $error("status read does not match running state");
    property p_cnt_ro;
        @(posedge I_CLK) disable iff (I_RST)
        (!running & !cmd_clear) |=> $stable(cnt_r);
    endproperty
    a_cnt_ro: assert property (p_cnt_ro)
        else $error("counter changed without running or clear");
    property p_clear_start;
        @(posedge I_CLK) disable iff (I_RST)
        (cmd_clear & cmd_start & !cmd_stop)
            |=> (cnt_r == 16'h0000) && O_RUNNING && clear_pend_r;
    endproperty
    a_clear_start: assert property (p_clear_start)
        else $error("clear with start did not zero and run");
    property p_reload;
        @(posedge I_CLK) disable iff (I_RST)
        (step & at_zero & !cmd_clear)
            |=> cnt_r == ($past(ctrl_r.top_from_match_a) ? $past(match_a_value_r) : 16'hFFFF);
    endproperty
    a_reload: assert property (p_reload)
        else $error("underflow reload value wrong");
    property p_uf_flag;
        @(posedge I_CLK) disable iff (I_RST)
        uf |=> flags_r.underflow_flag;
    endproperty
    a_uf_flag: assert property (p_uf_flag)
        else $error("underflow flag not raised");
    property p_no_uf_after_clear;
        @(posedge I_CLK) disable iff (I_RST)
        cmd_clear |=> !uf;
    endproperty
    a_no_uf_after_clear: assert property (p_no_uf_after_clear)
        else $error("underflow raised on wrap after clear");
    property p_oneshot_stop;
        @(posedge I_CLK) disable iff (I_RST)
        (uf & (ctrl_r.repeat_policy_select == ldt_pkg::RP_ONESHOT) & rep_a_last
            & !start_any & !wr_rep_a) |=> !O_RUNNING && (rep_a_r == 8'h00);
    endproperty
    a_oneshot_stop: assert property (p_oneshot_stop)
        else $error("one-shot did not stop at count zero");
    property p_rep_write;
        @(posedge I_CLK) disable iff (I_RST)
        wr_rep_a |=> rep_a_r == $past(I_PWDATA[7:0]);
    endproperty
    a_rep_write: assert property (p_rep_write)
        else $error("repeat count A write lost");
    property p_match_a_value_write;
        @(posedge I_CLK) disable iff (I_RST)
        wr_match_a_value |=> match_a_value_r == $past(I_PWDATA[15:0]);
    endproperty
    a_match_a_value_write: assert property (p_match_a_value_write)
        else $error("match_a_value write lost to buffer load");
    property p_freeze;
        @(posedge I_CLK) disable iff (I_RST)
        (freeze & running & !cmd_clear & !cmd_stop) |=> $stable(cnt_r) && O_RUNNING;
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("counter moved while frozen");
    c_oneshot_end: cover property (@(posedge I_CLK) disable iff (I_RST)
        uf & (ctrl_r.repeat_policy_select == ldt_pkg::RP_ONESHOT) & rep_a_last);
    c_buf_reload: cover property (@(posedge I_CLK) disable iff (I_RST)
        uf & (ctrl_r.repeat_policy_select == ldt_pkg::RP_BUFFERED) & rep_a_last
        & !reload_consumed_r & (rep_b_r != 8'h00));
    c_double_b: cover property (@(posedge I_CLK) disable iff (I_RST)
        uf & (ctrl_r.repeat_policy_select == ldt_pkg::RP_DOUBLE) & (rep_b_r == 8'h01));
    c_trigger: cover property (@(posedge I_CLK) disable iff (I_RST)
        trig & !running);

endmodule : ldt_timer

`default_nettype wire

// *** bench/ldt_rtc_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module ldt_rtc_model (
    input wire logic i_clk,        // Clock shared with the timer
    input wire logic [1:0] i_fire, // Bench request, one bit per channel
    output logic o_match0,         // Channel 0 compare match pulse
    output logic o_match1          // Channel 1 compare match pulse
);
    // Equal clock rates: each match is one pulse, so it triggers once
    always_ff @(posedge i_clk)
    begin
        o_match0 <= i_fire[0];
        o_match1 <= i_fire[1];
    end
endmodule : ldt_rtc_model

`default_nettype wire

// *** bench/ldt_timer_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ldt_params.svh"

module ldt_timer_test;
    logic clk, rst, psel, pen, pwr, tick, halted, running, m0, m1, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [1:0] fire_r;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    ldt_timer u_ldt_timer (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TICK(tick), .I_RTC_MATCH0(m0),
        .I_RTC_MATCH1(m1), .I_CPU_HALTED(halted), .O_RUNNING(running));

    ldt_rtc_model u_ldt_rtc_model (.i_clk(clk), .i_fire(fire_r), .o_match0(m0),
        .o_match1(m1));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic stop_test;
        $display("compares %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        check({31'h0, pslverr}, {31'h0, a >= 12'h028});
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask : rd

    task automatic tk(input int n);
        repeat (n)
        begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
    endtask : tk

    task automatic run_is(input logic e);
        @(negedge clk);
        check({31'h0, running}, {31'h0, e});
    endtask : run_is

    task automatic fire(input int ch);
        @(posedge clk);
        fire_r <= 2'(1 << ch);
        @(posedge clk);
        fire_r <= 2'h0;
        repeat (2) @(posedge clk);
    endtask : fire

    // ----------------------------------------
    // Clock, reset and hang guard
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    initial
    begin
        {rst, psel, pen, pwr, tick, halted} = 6'h21;
        halted = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        fire_r = 2'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(`LDT_OFF_CTRL, 32'h0);
        rd(`LDT_OFF_CNT, 32'h0);
        rd(`LDT_OFF_CMD, 32'h0);
        rd(12'h040, 32'h0);
        wr(`LDT_OFF_REPEAT_COUNT_B, 32'h1FF);
        rd(`LDT_OFF_REPEAT_COUNT_B, 32'hFF);
        $display("reset and map test done");
        wr(`LDT_OFF_CMD, 32'h5);
        run_is(1'b1);
        rd(`LDT_OFF_STATUS, 32'h1);
        tk(1);
        rd(`LDT_OFF_CNT, 32'hFFFF);
        rd(`LDT_OFF_FLAGS, 32'h6);
        wr(`LDT_OFF_CNT, 32'h1234);
        tk(1);
        rd(`LDT_OFF_CNT, 32'hFFFE);
        wr(`LDT_OFF_CMD, 32'h3);
        run_is(1'b0);
        tk(1);
        rd(`LDT_OFF_CNT, 32'hFFFE);
        $display("start stop test done");
        wr(`LDT_OFF_CTRL, 32'h1);
        wr(`LDT_OFF_MATCH_A_VALUE, 32'h3);
        wr(`LDT_OFF_MATCH_B_VALUE, 32'h2);
        wr(`LDT_OFF_CMD, 32'h5);
        tk(1);
        rd(`LDT_OFF_CNT, 32'h3);
        tk(4);
        rd(`LDT_OFF_CNT, 32'h3);
        rd(`LDT_OFF_FLAGS, 32'h7);
        wr(`LDT_OFF_FLAGCLR, 32'h1F);
        rd(`LDT_OFF_FLAGS, 32'h0);
        $display("top and match test done");
        wr(`LDT_OFF_CMD, 32'h6);
        wr(`LDT_OFF_CTRL, 32'h5);
        wr(`LDT_OFF_REPEAT_COUNT_A, 32'h2);
        wr(`LDT_OFF_CMD, 32'h5);
        tk(8);
        run_is(1'b1);
        tk(1);
        run_is(1'b0);
        rd(`LDT_OFF_REPEAT_COUNT_A, 32'h0);
        rd(`LDT_OFF_FLAGS, 32'hF);
        $display("one-shot test done");
        for (int ch = 0; ch < 2; ch++)
        begin
            wr(`LDT_OFF_CTRL, 32'h1 | (32'h10 << ch));
            fire(1 - ch);
            run_is(1'b0);
            fire(ch);
            run_is(1'b1);
            fire(ch);
            run_is(1'b1);
            wr(`LDT_OFF_CMD, 32'h2);
        end
        $display("trigger test done");
        wr(`LDT_OFF_CMD, 32'h6);
        wr(`LDT_OFF_FLAGCLR, 32'h1F);
        wr(`LDT_OFF_CTRL, 32'hB);
        wr(`LDT_OFF_REPEAT_COUNT_B, 32'h2);
        wr(`LDT_OFF_CMD, 32'h1);
        run_is(1'b1);
        rd(`LDT_OFF_REPEAT_COUNT_A, 32'h2);
        tk(10);
        run_is(1'b0);
        rd(`LDT_OFF_REPEAT_COUNT_A, 32'h0);
        rd(`LDT_OFF_MATCH_A_VALUE, 32'h2);
        wr(`LDT_OFF_REPEAT_COUNT_A, 32'h1);
        wr(`LDT_OFF_REPEAT_COUNT_B, 32'h1);
        wr(`LDT_OFF_CMD, 32'h5);
        tk(4);
        run_is(1'b1);
        rd(`LDT_OFF_REPEAT_COUNT_A, 32'h1);
        tk(3);
        run_is(1'b0);
        $display("buffered test done");
        wr(`LDT_OFF_CMD, 32'h6);
        wr(`LDT_OFF_FLAGCLR, 32'h1F);
        wr(`LDT_OFF_CTRL, 32'hD);
        wr(`LDT_OFF_REPEAT_COUNT_A, 32'h1);
        wr(`LDT_OFF_REPEAT_COUNT_B, 32'h3);
        wr(`LDT_OFF_CMD, 32'h5);
        tk(9);
        run_is(1'b1);
        rd(`LDT_OFF_REPEAT_COUNT_A, 32'h0);
        rd(`LDT_OFF_REPEAT_COUNT_B, 32'h1);
        tk(1);
        run_is(1'b0);
        rd(`LDT_OFF_FLAGS, 32'h1F);
        wr(`LDT_OFF_REPEAT_COUNT_A, 32'h1);
        wr(`LDT_OFF_CMD, 32'h5);
        tk(3);
        wr(`LDT_OFF_REPEAT_COUNT_B, 32'h2);
        tk(1);
        run_is(1'b1);
        tk(3);
        run_is(1'b0);
        $display("double test done");
        wr(`LDT_OFF_CMD, 32'h6);
        wr(`LDT_OFF_CTRL, 32'h1);
        wr(`LDT_OFF_CMD, 32'h5);
        tk(1);
        halted <= 1'b1;
        tk(4);
        rd(`LDT_OFF_CNT, 32'h0);
        run_is(1'b1);
        wr(`LDT_OFF_CTRL, 32'h41);
        tk(2);
        rd(`LDT_OFF_CNT, 32'h1);
        halted <= 1'b0;
        $display("debug test done");
        stop_test();
    end
endmodule : ldt_timer_test

`default_nettype wire
